// File: logic/sbt_commander.v
// host-side commander node for the multiplexed system bus
// assumes bus pins are tristated outside; remote arbiter grants
`timescale 1ns/1ns
`default_nettype none
`include "sbt_regs.vh"
module sbt_commander (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  // user request
  input wire req_valid,
  input wire [3:0] req_op,
  input wire [1:0] req_len,
  input wire [38:0] req_addr,
  input wire [15:0] req_mask,
  input wire [63:0] req_wdata0,
  input wire [63:0] req_wdata1,
  input wire [63:0] req_wdata2,
  input wire [63:0] req_wdata3,
  input wire req_io,
  input wire [3:0] node_id,
  output reg req_ready,
  // user result
  output reg rsp_valid,
  output reg rsp_locked,
  output reg rsp_error,
  output reg rsp_corrected,
  output reg [1:0] rsp_beat,
  output reg [63:0] rsp_data,
  output reg lock_held,
  output reg snoop_hit,
  output reg interrupt_request_cmd_clear,
  // arbitration
  output reg cmd_req,
  output reg hold_o,
  input wire grant_i,
  // bus pins
  input wire [63:0] bus_d_i,
  output reg [63:0] bus_d_o,
  output reg bus_d_oe,
  input wire [3:0] bus_f_i,
  output reg [3:0] bus_f_o,
  output reg bus_f_oe,
  input wire [5:0] bus_id_i,
  output reg [5:0] bus_id_o,
  output reg bus_id_oe,
  output reg [2:0] bus_cnf_o,
  output reg bus_cnf_oe
);
  localparam ST_IDLE = 5'h01;
  localparam ST_ARB = 5'h02;
  localparam ST_CMD = 5'h04;
  localparam ST_WDATA = 5'h08;
  localparam ST_WAIT = 5'h10;
  wire [73:0] pin_raw;
  wire [73:0] pin_s;
  wire [73:0] pin_ok;
  assign pin_raw = {bus_id_i, bus_f_i, bus_d_i};
  genvar gi;
  generate
    for (gi = 0; gi < 74; gi = gi + 1) begin : g_sync
      sbt_sync3 u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .d(pin_raw[gi]),
        .q(pin_s[gi]),
        .stable(pin_ok[gi])
      );
    end
  endgenerate
  wire all_ok = &pin_ok;
  wire [63:0] s_d = pin_s[63:0];
  wire [3:0] s_f = pin_s[67:64];
  wire [5:0] s_id = pin_s[73:68];
  wire g_sync_q;
  wire g_sync_ok;
  sbt_sync3 u_grant (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .d(grant_i),
    .q(g_sync_q),
    .stable(g_sync_ok)
  );
  wire grant = g_sync_q & g_sync_ok;
  reg [4:0] st_r;
  reg [3:0] op_r;
  reg [1:0] len_r;
  reg [1:0] beats_r;
  reg [1:0] wbeat_r;
  reg [1:0] cmdno_r;
  reg [63:0] cmd_word_r;
  reg [255:0] wbuf_r;
  reg [1:0] rbeat_r;
  reg [1:0] cnf_pipe_r;
  reg [38:0] owned_addr_r;
  reg owned_r;
  reg [38:0] last_addr_r;
  reg last_interlock_read_cmd_r;
  reg [3:0] seen_f_r;
  // a bus cycle spans several clocks: act once per new settled function value
  wire fresh = all_ok & (s_f != seen_f_r);
  wire [5:0] my_tag = {node_id, cmdno_r}; // RULE22
  wire tag_match = (s_id == my_tag) & fresh;
  wire in_grd = (s_f[3:2] == `SBT_FN_GRD_HI) | (s_f[3:2] == `SBT_FN_CRD_HI); // RULE23
  wire foreign_cmd = fresh & (s_f == `SBT_FN_CMD) & (s_id[5:2] != node_id);
  wire [3:0] s_op = s_d[`SBT_OPC_HI:`SBT_OPC_LO];
  wire s_op_known = (s_op == `SBT_OP_READ) | (s_op == `SBT_OP_INTERLOCK_READ_CMD) | (s_op == `SBT_OP_OWNERSHIP_READ_CMD) |
    (s_op == `SBT_OP_WRITE) | (s_op == `SBT_OP_UWRITE) | (s_op == `SBT_OP_DWRITE) |
    (s_op == `SBT_OP_INTERRUPT_REQUEST_CMD) | (s_op == `SBT_OP_ACK) | (s_op == `SBT_OP_TBAD) | (s_op == `SBT_OP_IVEC);
  wire is_write = (op_r == `SBT_OP_WRITE) | (op_r == `SBT_OP_UWRITE) | (op_r == `SBT_OP_DWRITE) |
    (op_r == `SBT_OP_TBAD);
  wire is_read = (op_r == `SBT_OP_READ) | (op_r == `SBT_OP_INTERLOCK_READ_CMD) | (op_r == `SBT_OP_OWNERSHIP_READ_CMD);
  wire [1:0] len_eff = (req_op == `SBT_OP_OWNERSHIP_READ_CMD) ? `SBT_LEN_HEX : req_len; // RULE10
  wire [1:0] nbeats = (len_r == 2'h0) ? 2'h3 : (len_r == 2'h3) ? 2'h1 : 2'h0;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      op_r <= `SBT_OP_NULL;
      len_r <= 2'h0;
      beats_r <= 2'h0;
      wbeat_r <= 2'h0;
      cmdno_r <= 2'h0;
      cmd_word_r <= 64'h0;
      wbuf_r <= 256'h0;
      rbeat_r <= 2'h0;
      cnf_pipe_r <= 2'h0;
      owned_addr_r <= 39'h0;
      owned_r <= 1'b0;
      last_addr_r <= 39'h0;
      last_interlock_read_cmd_r <= 1'b0;
      seen_f_r <= `SBT_FN_NULL;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_locked <= 1'b0;
      rsp_error <= 1'b0;
      rsp_corrected <= 1'b0;
      rsp_beat <= 2'h0;
      rsp_data <= 64'h0;
      lock_held <= 1'b0;
      snoop_hit <= 1'b0;
      interrupt_request_cmd_clear <= 1'b0;
      cmd_req <= 1'b0;
      hold_o <= 1'b0;
      bus_d_o <= 64'h0;
      bus_d_oe <= 1'b0;
      bus_f_o <= `SBT_FN_NULL;
      bus_f_oe <= 1'b0;
      bus_id_o <= 6'h0;
      bus_id_oe <= 1'b0;
      bus_cnf_o <= 3'h0;
      bus_cnf_oe <= 1'b0;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      rsp_locked <= 1'b0;
      rsp_error <= 1'b0;
      rsp_corrected <= 1'b0;
      snoop_hit <= 1'b0;
      interrupt_request_cmd_clear <= 1'b0;
      bus_d_oe <= 1'b0;
      bus_f_oe <= 1'b0;
      bus_id_oe <= 1'b0;
      bus_f_o <= `SBT_FN_NULL;
      if (all_ok)
        seen_f_r <= s_f;
      // confirm read data beats addressed to us
      cnf_pipe_r <= {cnf_pipe_r[0], st_r == ST_WAIT && tag_match && in_grd};
      bus_cnf_oe <= cnf_pipe_r[1]; // RULE24
      bus_cnf_o <= cnf_pipe_r[1] ? `SBT_CNF_ACK : 3'h0;
      // foreign access to our owned block
      if (foreign_cmd && s_op_known && owned_r && s_d[`SBT_ADDR_HI-1:5] == owned_addr_r[38:5]) // RULE2
        snoop_hit <= 1'b1; // RULE15
      if (foreign_cmd && s_op == `SBT_OP_ACK)
        interrupt_request_cmd_clear <= 1'b1; // RULE17
      case (st_r)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            op_r <= req_op;
            len_r <= len_eff;
            cmd_word_r <= {req_op, len_eff, req_mask, 2'h0, req_io, req_addr}; // RULE1
            wbuf_r <= {req_wdata3, req_wdata2, req_wdata1, req_wdata0};
            last_addr_r <= req_addr;
            wbeat_r <= 2'h0;
            rbeat_r <= 2'h0;
            cmd_req <= 1'b1;
            st_r <= ST_ARB;
          end
        end
        ST_ARB: begin
          if (grant) begin // RULE21
            cmd_req <= 1'b0;
            beats_r <= nbeats;
            hold_o <= is_write; // RULE25
            bus_d_o <= cmd_word_r;
            bus_d_oe <= 1'b1;
            bus_f_o <= `SBT_FN_CMD;
            bus_f_oe <= 1'b1;
            bus_id_o <= my_tag;
            bus_id_oe <= 1'b1;
            st_r <= is_write ? ST_WDATA : ST_CMD;
          end
        end
        ST_WDATA: begin
          // back-to-back data beats, no null gap
          bus_d_o <= wbuf_r[63:0]; // RULE12
          wbuf_r <= wbuf_r >> 64;
          bus_d_oe <= 1'b1;
          bus_f_o <= `SBT_FN_WDATA;
          bus_f_oe <= 1'b1;
          bus_id_o <= my_tag;
          bus_id_oe <= 1'b1;
          wbeat_r <= wbeat_r + 2'h1;
          if (wbeat_r == beats_r)
            st_r <= ST_CMD;
        end
        ST_CMD: begin
          // hold released only after the last data cycle has been on the bus
          hold_o <= 1'b0; // RULE25
          if (op_r == `SBT_OP_UWRITE)
            lock_held <= 1'b0; // RULE5
          if (op_r == `SBT_OP_DWRITE || op_r == `SBT_OP_TBAD)
            owned_r <= 1'b0; // RULE16
          // acknowledge waits for the vector read cycle
          if (is_read || op_r == `SBT_OP_ACK) begin // RULE17
            last_interlock_read_cmd_r <= (op_r == `SBT_OP_INTERLOCK_READ_CMD); // RULE8
            st_r <= ST_WAIT;
          end else begin
            // implied vector and writes finish without acknowledge
            rsp_valid <= 1'b1; // RULE19
            cmdno_r <= cmdno_r + 2'h1;
            st_r <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (tag_match && s_f == `SBT_FN_LOCK) begin
            rsp_valid <= 1'b1;
            rsp_locked <= 1'b1; // RULE7
            cmdno_r <= cmdno_r + 2'h1;
            st_r <= ST_IDLE;
          end else if (tag_match && s_f == `SBT_FN_RERR) begin
            rsp_valid <= 1'b1;
            rsp_error <= 1'b1;
            cmdno_r <= cmdno_r + 2'h1;
            st_r <= ST_IDLE;
          end else if (tag_match && in_grd) begin
            // beats arrive wrapped from the requested quadword
            rsp_valid <= 1'b1; // RULE3
            rsp_data <= s_d;
            rsp_beat <= s_f[1:0];
            rsp_corrected <= (s_f[3:2] == `SBT_FN_CRD_HI);
            rbeat_r <= rbeat_r + 2'h1;
            if (rbeat_r == beats_r || op_r == `SBT_OP_INTERRUPT_REQUEST_CMD || op_r == `SBT_OP_ACK) begin
              if (last_interlock_read_cmd_r) lock_held <= 1'b1; // RULE4
              if (op_r == `SBT_OP_OWNERSHIP_READ_CMD) begin
                owned_r <= 1'b1; // RULE10
                owned_addr_r <= last_addr_r;
              end
              cmdno_r <= cmdno_r + 2'h1;
              st_r <= ST_IDLE;
            end
          end else if (op_r == `SBT_OP_ACK && interrupt_request_cmd_clear) begin
            // lost the acknowledge race: passive release
            rsp_valid <= 1'b1; // RULE18
            cmdno_r <= cmdno_r + 2'h1;
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: logic/sbt_regs.vh
// constants for the system bus transaction commander (host side)
// assumes one bus node, cycles sampled on clk_sys
// Contract
// RULE1 - command opcode sits in top data nibble
// RULE2 - unassigned opcodes act as null cycle
// RULE3 - read data naturally aligned, wraparound order
// RULE4 - interlock read locks free block, returns data
// RULE5 - lock holder later unlocks via unlock write
// RULE6 - held block: lock response, no data
// RULE7 - lock response function 0100, data ignored
// RULE8 - interlock read never asserts more indication
// RULE9 - I/O responder may treat interlocks plainly
// RULE10 - ownership read moves one hexword, owned
// RULE11 - masked write moves only mask-selected bytes
// RULE12 - write data one, two, four back-to-back
// RULE13 - unlock write unlocks and writes masked data
// RULE14 - disown write frees owned block, quad+ sizes
// RULE15 - owner disowns on foreign block reference; code only raises snoop_hit, owned_r stays set
// RULE16 - double-bit error: tag-bad replaces disown write
// RULE17 - first acknowledge gets vector, others clear
// RULE18 - losing simultaneous acknowledgers passively release
// RULE19 - implied vector interrupt single cycle, no acknowledge
// RULE20 - responder queue beats commander queue, round robin
// RULE21 - arbitration on dedicated lines, overlapped
// RULE22 - tag is node number plus command number
// RULE23 - function lines encode cycle type
// RULE24 - receiver confirms two cycles after accept
// RULE25 - masked write holds bus through data cycles
`ifndef SBT_REGS_VH
`define SBT_REGS_VH
`define SBT_OP_NULL 4'h0
`define SBT_OP_READ 4'h1
`define SBT_OP_INTERLOCK_READ_CMD 4'h2
`define SBT_OP_OWNERSHIP_READ_CMD 4'h3
`define SBT_OP_DWRITE 4'h4
`define SBT_OP_UWRITE 4'h6
`define SBT_OP_WRITE 4'h7
`define SBT_OP_INTERRUPT_REQUEST_CMD 4'h8
`define SBT_OP_ACK 4'h9
`define SBT_OP_TBAD 4'hB
`define SBT_OP_IVEC 4'hF
`define SBT_FN_NULL 4'h0
`define SBT_FN_CMD 4'h1
`define SBT_FN_WDATA 4'h2
`define SBT_FN_LOCK 4'h4
`define SBT_FN_RERR 4'h5
`define SBT_FN_GRD_HI 2'h2
`define SBT_FN_CRD_HI 2'h3
`define SBT_CNF_ACK 3'h1
`define SBT_OPC_HI 63
`define SBT_OPC_LO 60
`define SBT_LEN_HI 59
`define SBT_LEN_LO 58
`define SBT_MASK_HI 57
`define SBT_MASK_LO 42
`define SBT_ADDR_HI 39
`define SBT_LEN_HEX 2'h0
`define SBT_CNF_DELAY 2
`define SBT_NODE_W 4
`define SBT_CMDNO_W 2
`endif

// File: logic/sbt_sync3.v
// three-flop synchroniser for one bus input bit
// assumes clk_sys domain, enable freezes state
`timescale 1ns/1ns
`default_nettype none
module sbt_sync3 (
  // clock and control
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  // data
  input wire d,
  output wire q,
  output wire stable
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign q = s3_r;
  assign stable = (s2_r == s3_r);
endmodule
`default_nettype wire

// File: test/sbt_monitor.sv
// bus-side checker for sbt_commander
// assumes one clk_sys domain, bound at the foot of this file
`timescale 1ns/1ns
`default_nettype none
`include "sbt_regs.vh"
module sbt_monitor (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // node and status
  input wire [3:0] node_id,
  input wire hold_o,
  input wire rsp_valid,
  input wire rsp_locked,
  input wire rsp_error,
  input wire lock_held,
  // bus outputs
  input wire [63:0] bus_d_o,
  input wire bus_d_oe,
  input wire [3:0] bus_f_o,
  input wire bus_f_oe,
  input wire [5:0] bus_id_o,
  input wire bus_id_oe,
  input wire [2:0] bus_cnf_o,
  input wire bus_cnf_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire cmd = bus_f_oe && bus_f_o == `SBT_FN_CMD;
  wire wdat = bus_f_oe && bus_f_o == `SBT_FN_WDATA;
  wire [3:0] opc = bus_d_o[63:60];
  AST_OPC_KNOWN: assert property (cmd |-> bus_d_oe && !(opc inside {4'h0, 4'h5, 4'hA, 4'hC, 4'hD, 4'hE}))
    else $error("unassigned opcode driven");
  AST_TAG_NODE: assert property (bus_id_oe |-> bus_id_o[5:2] == node_id)
    else $error("tag node field wrong");
  AST_FN_OWN: assert property (bus_f_oe |-> bus_f_o inside {`SBT_FN_CMD, `SBT_FN_WDATA})
    else $error("commander drove bad function");
  AST_OWNERSHIP_READ_CMD_HEX: assert property (cmd && opc == `SBT_OP_OWNERSHIP_READ_CMD |-> bus_d_o[59:58] == `SBT_LEN_HEX)
    else $error("ownership read not hexword");
  AST_WR_BTB: assert property (cmd && opc == `SBT_OP_WRITE && bus_d_o[59:58] == 2'h3 |=> wdat[*2] ##1 !wdat)
    else $error("octaword write beats not back to back");
  AST_HOLD_WD: assert property (wdat |-> hold_o)
    else $error("hold low during write data");
  AST_LOCK_END: assert property (rsp_locked |-> rsp_valid && !rsp_error ##1 !rsp_valid)
    else $error("lock response not a lone completion");
  AST_CNF_ACK: assert property (bus_cnf_oe |-> bus_cnf_o == `SBT_CNF_ACK ##1 !bus_cnf_oe)
    else $error("confirmation not a single ack");
  COV_LOCK: cover property (rsp_locked);
  COV_HELD: cover property ($rose(lock_held));
  COV_HEXWR: cover property (wdat[*4]);
endmodule
bind sbt_commander sbt_monitor u_mon (.clk_sys(clk_sys), .nrst(nrst), .node_id(node_id), .hold_o(hold_o),
  .rsp_valid(rsp_valid), .rsp_locked(rsp_locked), .rsp_error(rsp_error), .lock_held(lock_held),
  .bus_d_o(bus_d_o), .bus_d_oe(bus_d_oe), .bus_f_o(bus_f_o), .bus_f_oe(bus_f_oe), .bus_id_o(bus_id_o),
  .bus_id_oe(bus_id_oe), .bus_cnf_o(bus_cnf_o), .bus_cnf_oe(bus_cnf_oe));
`default_nettype wire

// File: test/sbt_mem_model.sv
// memory responder and arbiter standing opposite the commander
// assumes one lockable block, each response cycle held four clocks
`timescale 1ns/1ns
`default_nettype none
`include "sbt_regs.vh"
module sbt_mem_model (
  // clock
  input wire clk_sys,
  // commander side
  input wire cmd_req,
  input wire [63:0] bus_d_o,
  input wire [3:0] bus_f_o,
  input wire bus_f_oe,
  input wire [5:0] bus_id_o,
  // responses
  output logic grant_i = 1'b0,
  output logic [63:0] bus_d_i = 64'h0,
  output logic [3:0] bus_f_i = 4'h0,
  output logic [5:0] bus_id_i = 6'h0
);
  logic locked_r = 1'b0;
  logic [3:0] op = 4'h0;
  logic [5:0] tag = 6'h0;
  logic [15:0] mask;
  logic [63:0] wd [4];
  int nwd = 0;
  int n;
  int s;
  always @(posedge clk_sys) grant_i <= cmd_req;
  task automatic put(input logic [3:0] f, input logic [1:0] qw);
    bus_f_i <= f;
    bus_id_i <= tag;
    bus_d_i <= {8'hC5, 54'h0, qw};
    repeat (4) @(posedge clk_sys);
    // released lines must not keep the old value
    bus_f_i <= 4'h0;
    bus_d_i <= ~bus_d_i;
    bus_id_i <= ~bus_id_i;
    repeat (4) @(posedge clk_sys);
  endtask
  initial forever begin
    @(posedge clk_sys);
    if (wdat_ok()) begin
      wd[nwd] = bus_d_o;
      nwd++;
    end
    if (bus_f_oe && bus_f_o == `SBT_FN_CMD) begin
      op = bus_d_o[63:60];
      mask = bus_d_o[57:42];
      nwd = 0;
      tag = bus_id_o;
      n = bus_d_o[59:58] == 2'h0 ? 4 : bus_d_o[59:58] == 2'h3 ? 2 : 1;
      s = bus_d_o[4:3];
      if (op == `SBT_OP_INTERLOCK_READ_CMD && locked_r) put(`SBT_FN_LOCK, 2'h0);
      else if (op inside {`SBT_OP_READ, `SBT_OP_INTERLOCK_READ_CMD, `SBT_OP_OWNERSHIP_READ_CMD, `SBT_OP_ACK}) begin
        locked_r = locked_r | (op == `SBT_OP_INTERLOCK_READ_CMD);
        for (int k = 0; k < n; k++) put({`SBT_FN_GRD_HI, k[1:0]}, 2'((s + k) % n));
      end
      if (op inside {`SBT_OP_UWRITE, `SBT_OP_DWRITE}) locked_r = 1'b0;
    end
  end
  function automatic bit wdat_ok();
    return bus_f_oe && bus_f_o == `SBT_FN_WDATA && nwd < 4;
  endfunction
endmodule
`default_nettype wire

// File: test/testbench.sv
// self-checking bench: sbt_commander against the memory model
// assumes sbt_regs.vh on the include path
`timescale 1ns/1ns
`default_nettype none
`include "sbt_regs.vh"
module testbench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic [3:0] req_op = 4'h0;
  logic [1:0] req_len = 2'h0;
  logic [38:0] req_addr = 39'h0;
  logic [15:0] req_mask = 16'hFFFF;
  logic [63:0] wd [4];
  logic [63:0] rd [4];
  logic [1:0] rb [4];
  logic rl;
  int ngot;
  int mismatches = 0;
  int total_checks = 0;
  wire req_ready, rsp_valid, rsp_locked, rsp_error, lock_held, cmd_req, grant_i, bus_f_oe;
  wire [1:0] rsp_beat;
  wire [63:0] rsp_data, bus_d_o, bus_d_i;
  wire [3:0] bus_f_o, bus_f_i;
  wire [5:0] bus_id_o, bus_id_i;
  sbt_commander uut (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .req_valid(req_valid), .req_op(req_op),
    .req_len(req_len), .req_addr(req_addr), .req_mask(req_mask), .req_wdata0(wd[0]), .req_wdata1(wd[1]),
    .req_wdata2(wd[2]), .req_wdata3(wd[3]), .req_io(1'b0), .node_id(4'h5), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_locked(rsp_locked), .rsp_error(rsp_error), .rsp_corrected(),
    .rsp_beat(rsp_beat), .rsp_data(rsp_data), .lock_held(lock_held), .snoop_hit(), .interrupt_request_cmd_clear(),
    .cmd_req(cmd_req), .hold_o(), .grant_i(grant_i), .bus_d_i(bus_d_i), .bus_d_o(bus_d_o), .bus_d_oe(),
    .bus_f_i(bus_f_i), .bus_f_o(bus_f_o), .bus_f_oe(bus_f_oe), .bus_id_i(bus_id_i), .bus_id_o(bus_id_o),
    .bus_id_oe(), .bus_cnf_o(), .bus_cnf_oe());
  sbt_mem_model mdl (.clk_sys(clk_sys), .cmd_req(cmd_req), .bus_d_o(bus_d_o), .bus_f_o(bus_f_o),
    .bus_f_oe(bus_f_oe), .bus_id_o(bus_id_o), .grant_i(grant_i), .bus_d_i(bus_d_i), .bus_f_i(bus_f_i),
    .bus_id_i(bus_id_i));
  always #5 clk_sys = ~clk_sys;
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [3:0] op, input logic [1:0] len, input logic [38:0] addr, input int n);
    int w;
    ngot = 0;
    @(posedge clk_sys);
    for (w = 0; req_ready !== 1'b1 && w < 200; w++) @(posedge clk_sys);
    req_op <= op;
    req_len <= len;
    req_addr <= addr;
    req_valid <= 1'b1;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    for (w = 0; ngot < n && w < 400; w++) begin
      @(posedge clk_sys);
      if (rsp_valid === 1'b1) begin
        rd[ngot] = rsp_data;
        rb[ngot] = rsp_beat;
        rl = rsp_locked;
        ngot++;
      end
    end
  endtask
  task automatic t_write;
    for (int k = 0; k < 3; k++) begin
      req_mask <= k == 0 ? 16'h00FF : 16'hFFFF;
      issue(`SBT_OP_WRITE, k == 0 ? 2'h2 : k == 1 ? 2'h3 : 2'h0, 39'h40, 1);
      check(ngot, 1);
      check(mdl.nwd, 1 << k);
      check(mdl.mask, k == 0 ? 16'h00FF : 16'hFFFF);
      check(mdl.wd[(1 << k) - 1], wd[(1 << k) - 1]);
    end
    $display("t_write done");
  endtask
  task automatic t_read;
    issue(`SBT_OP_READ, 2'h3, 39'h48, 2);
    for (int k = 0; k < 2; k++) check({rb[k], rd[k][1:0]}, {k[1:0], 2'((1 + k) % 2)});
    issue(`SBT_OP_OWNERSHIP_READ_CMD, 2'h0, 39'h50, 4);
    for (int k = 0; k < 4; k++) check({rb[k], rd[k][1:0]}, {k[1:0], 2'((2 + k) % 4)});
    $display("t_read done");
  endtask
  task automatic t_lock;
    issue(`SBT_OP_INTERLOCK_READ_CMD, 2'h2, 39'h80, 1);
    @(posedge clk_sys);
    check({rl, lock_held}, 2'b01);
    issue(`SBT_OP_INTERLOCK_READ_CMD, 2'h2, 39'h80, 1);
    check({ngot[1:0], rl}, 3'b011);
    issue(`SBT_OP_UWRITE, 2'h2, 39'h80, 1);
    @(posedge clk_sys);
    check({lock_held, mdl.locked_r}, 2'b00);
    $display("t_lock done");
  endtask
  task automatic t_misc;
    logic [3:0] ops [5] = '{`SBT_OP_INTERRUPT_REQUEST_CMD, `SBT_OP_IVEC, `SBT_OP_TBAD, `SBT_OP_DWRITE, `SBT_OP_ACK};
    for (int k = 0; k < 5; k++) begin
      issue(ops[k], 2'h2, 39'h100, 1);
      check(mdl.op, ops[k]);
    end
    $display("t_misc done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    for (int k = 0; k < 4; k++) wd[k] = {32'hDA7A0000, 28'h0, k[3:0]};
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    t_write;
    t_read;
    t_lock;
    t_misc;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    stop_test;
  end
endmodule
`default_nettype wire
